// ==== src/isj_pkg.sv ====
// Constants, register map and types of the station indexer jog sequencer
package isj_pkg;
	// Clock and time base
	localparam int unsigned CLK_FREQ_HZ = 200_000_000;
	localparam int unsigned TL_DELAY_UNIT_MS = 1;
	localparam int unsigned TL_UNIT_CYC = CLK_FREQ_HZ / 1000 * TL_DELAY_UNIT_MS;
	localparam int unsigned SYNC_SETTLE_CYC = 3;

	// Register byte offsets
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_NEXT_STATION = 6'h04;
	localparam logic [5:0] OFS_SPEED_SELECT = 6'h08;
	localparam logic [5:0] OFS_CONFIG = 6'h0C;
	localparam logic [5:0] OFS_TL_DELAY = 6'h10;
	localparam logic [5:0] OFS_STATUS = 6'h14;
	localparam logic [5:0] OFS_IRQ_STATUS = 6'h18;
	localparam logic [5:0] OFS_IRQ_MASK = 6'h1C;
	localparam logic [5:0] OFS_TARGET = 6'h20;

	// Control register fields
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_MODE_ONE_BIT = 1;
	localparam int CTRL_MODE_TWO_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// Configuration register fields
	localparam int CFG_COUNT_LSB = 0;
	localparam int CFG_JOG_STYLE_BIT = 8;
	localparam int CFG_DIRECTION_BIT = 9;
	localparam int CFG_TWO_STATION_BIT = 10;
	localparam int CFG_DIRECT_SPEED_BIT = 11;
	localparam int CFG_OPERATION_BIT = 12;
	localparam logic [12:0] CFG_RESET = 13'h1_008;

	// Status register fields
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_INPOS_BIT = 1;
	localparam int STAT_TL_SECOND_BIT = 2;
	localparam int STAT_HOME_BIT = 3;
	localparam int STAT_STATE_LSB = 4;

	// Interrupt status fields
	localparam int IRQ_HOME_MISSING_BIT = 0;
	localparam int IRQ_RANGE_WARN_BIT = 1;
	localparam int IRQ_DONE_BIT = 2;
	localparam int IRQ_WIDTH = 3;

	// Other reset values
	localparam logic [7:0] NEXT_STATION_RESET = 8'h00;
	localparam logic [15:0] SPEED_SELECT_RESET = 16'h0000;
	localparam logic [15:0] TL_DELAY_RESET = 16'h0000;
	localparam logic [2:0] PT_ENTRY_ONE = 3'h1;

	// Command kinds for the motion engine
	localparam logic [1:0] CMD_INDEX = 2'h1;
	localparam logic [1:0] CMD_JOG = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_INDEX_MOVE = 3'b001,
		ST_JOG_RUN = 3'b010,
		ST_JOG_STOP = 3'b011
	} isj_state_e;
endpackage

// ==== src/isj_tl_if.sv ====
// Handshake between the sequencer and its torque limit delay timer
interface isj_tl_if;
	logic start;
	logic cancel;
	logic [15:0] delay;
	logic expired;

	modport ctl(output start, output cancel, output delay, input expired);
	modport tmr(input start, input cancel, input delay, output expired);
endinterface

// ==== src/isj_tl_delay.sv ====
// Delay timer before the second torque limit takes effect
module isj_tl_delay
	import isj_pkg::*;
#(
	parameter int unsigned UNIT_CYC = TL_UNIT_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	isj_tl_if.tmr tl
);
	logic [31:0] unit_cnt_q;
	logic [15:0] left_q;
	logic run_q;
	logic expired_q;

	assign tl.expired = expired_q;

	// Count whole delay units, then hold expired until next start or cancel
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			unit_cnt_q <= 32'h0000_0000;
			left_q <= 16'h0000;
			run_q <= 1'b0;
			expired_q <= 1'b0;
		end else if (tl.cancel) begin
			run_q <= 1'b0;
			expired_q <= 1'b0;
		end else if (tl.start) begin
			unit_cnt_q <= 32'h0000_0000;
			left_q <= tl.delay;
			run_q <= 1'b1;
			expired_q <= 1'b0;
		end else if (run_q) begin
			if (left_q == 16'h0000) begin
				run_q <= 1'b0;
				expired_q <= 1'b1;
			end else if (unit_cnt_q == UNIT_CYC - 1) begin
				unit_cnt_q <= 32'h0000_0000;
				left_q <= left_q - 16'h0001;
			end else begin
				unit_cnt_q <= unit_cnt_q + 32'h0000_0001;
			end
		end
	end
endmodule

// ==== src/isj_sequencer.sv ====
// Station indexer and jog command sequencer with Avalon-MM registers
//
// Overview of operation
// - Start without completed home return is refused and raises home-missing alarm.
// - Requested station above station count minus one raises the range warning.
// - Start requests during a running movement are ignored.
// - After in-position, wait the delay, then select the second torque limit.
// - At power-on, in-position is set when the motor sits at a station.
// - Direct speed only with two link stations; then ramps from entry one.
// - Mode one set with mode two clear selects manual operation.
// - Manual modes ignore station select and speed select bits.
// - Manual modes run with point table entry one while start is held.
// - Indexer jog release positions to the first reachable stopping station.
// - Plain jog release decelerates to a stop anywhere.
// - Jog modes use the configured torque limit delay after stopping.
// - Station allocation direction follows its parameter, zero after reset.
// - Auto mode takes target station and speed word before start.
module isj_sequencer
	import isj_pkg::*;
#(
	parameter int unsigned UNIT_CYC = TL_UNIT_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic home_done_i,
	input wire logic at_station_i,
	input wire logic move_done_i,
	output logic cmd_valid_o,
	output logic [1:0] cmd_kind_o,
	output logic [7:0] cmd_station_o,
	output logic [15:0] cmd_speed_o,
	output logic cmd_direct_speed_o,
	output logic [2:0] cmd_point_table_o,
	output logic cmd_direction_o,
	output logic jog_release_o,
	output logic jog_to_station_o,
	output logic tl_second_o,
	output logic motion_done_flag_o,
	output logic in_position_flag_o,
	output logic irq_o
);
	isj_tl_if tl_bus();

	logic [2:0] sync1_q, sync2_q, pin_in;
	logic home_s, at_station_s, move_done_s, move_done_prev_q, move_done_rise;

	logic wait_q, wr_go;
	logic [31:0] rdata_q, wmask, rd_mux;

	logic [2:0] ctrl_q;
	logic [7:0] next_station_word_q;
	logic [15:0] speed_select_word_q;
	logic [12:0] config_q;
	logic [15:0] torque_limit_delay_param_q;
	logic [IRQ_WIDTH-1:0] irq_stat_q, irq_mask_q, irq_set, irq_clr;

	logic start_request_bit, start_prev_q, start_rise;
	logic mode_select_one, mode_select_two, auto_mode, manual_mode;
	logic [7:0] station_count_param;
	logic jog_style_param, station_direction_param, two_station, direct_speed;
	logic operation_type_param, range_bad, start_ok;

	isj_state_e state_q;
	logic [1:0] settle_q;
	logic motion_done_q, in_position_q, tl_start_q, tl_cancel_q;

	// Two-flop synchronisers for the motion engine pins
	assign pin_in = {move_done_i, at_station_i, home_done_i};
	for (genvar i = 0; i < 3; i++) begin : g_sync
		always_ff @(posedge sys_clk_i) begin
			if (!rst_n_i) begin
				sync1_q[i] <= 1'b0;
				sync2_q[i] <= 1'b0;
			end else begin
				sync1_q[i] <= pin_in[i];
				sync2_q[i] <= sync1_q[i];
			end
		end
	end
	assign home_s = sync2_q[0];
	assign at_station_s = sync2_q[1];
	assign move_done_s = sync2_q[2];
	assign move_done_rise = move_done_s & ~move_done_prev_q;

	// Field views
	assign start_request_bit = ctrl_q[CTRL_START_BIT];
	assign mode_select_one = ctrl_q[CTRL_MODE_ONE_BIT];
	assign mode_select_two = ctrl_q[CTRL_MODE_TWO_BIT];
	assign station_count_param = config_q[CFG_COUNT_LSB +: 8];
	assign jog_style_param = config_q[CFG_JOG_STYLE_BIT];
	assign station_direction_param = config_q[CFG_DIRECTION_BIT];
	assign two_station = config_q[CFG_TWO_STATION_BIT];
	assign direct_speed = config_q[CFG_DIRECT_SPEED_BIT];
	assign operation_type_param = config_q[CFG_OPERATION_BIT];
	assign auto_mode = operation_type_param & mode_select_one & mode_select_two;
	assign manual_mode = operation_type_param & mode_select_one & ~mode_select_two;

	// Bus handshake: one wait cycle, then the access completes
	assign wr_go = avs_write_i & ~wait_q;
	always_comb begin
		wmask = 32'h0000_0000;
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			wait_q <= 1'b1;
		end else if ((avs_read_i | avs_write_i) & wait_q) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= 1'b1;
		end
	end
	assign avs_waitrequest_o = wait_q;

	// Read mux, unmapped offsets read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avs_address_i)
			OFS_CTRL: rd_mux[2:0] = ctrl_q;
			OFS_NEXT_STATION: rd_mux[7:0] = next_station_word_q;
			OFS_SPEED_SELECT: rd_mux[15:0] = speed_select_word_q;
			OFS_CONFIG: rd_mux[12:0] = config_q;
			OFS_TL_DELAY: rd_mux[15:0] = torque_limit_delay_param_q;
			OFS_STATUS: begin
				rd_mux[STAT_DONE_BIT] = motion_done_q;
				rd_mux[STAT_INPOS_BIT] = in_position_q;
				rd_mux[STAT_TL_SECOND_BIT] = tl_second_o;
				rd_mux[STAT_HOME_BIT] = home_s;
				rd_mux[STAT_STATE_LSB +: 3] = state_q;
			end
			OFS_IRQ_STATUS: rd_mux[IRQ_WIDTH-1:0] = irq_stat_q;
			OFS_IRQ_MASK: rd_mux[IRQ_WIDTH-1:0] = irq_mask_q;
			OFS_TARGET: rd_mux = {cmd_speed_o, 5'h00, cmd_point_table_o, cmd_station_o};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read_i & wait_q) begin
			rdata_q <= rd_mux;
		end
	end
	assign avs_readdata_o = rdata_q;

	// Software writable registers
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			ctrl_q <= CTRL_RESET;
			next_station_word_q <= NEXT_STATION_RESET;
			speed_select_word_q <= SPEED_SELECT_RESET;
			config_q <= CFG_RESET;
			torque_limit_delay_param_q <= TL_DELAY_RESET;
			irq_mask_q <= '0;
		end else if (wr_go) begin
			case (avs_address_i)
				OFS_CTRL: ctrl_q <= (ctrl_q & ~wmask[2:0]) | (avs_writedata_i[2:0] & wmask[2:0]);
				OFS_NEXT_STATION: next_station_word_q <= (next_station_word_q & ~wmask[7:0])
					| (avs_writedata_i[7:0] & wmask[7:0]);
				OFS_SPEED_SELECT: speed_select_word_q <= (speed_select_word_q & ~wmask[15:0])
					| (avs_writedata_i[15:0] & wmask[15:0]);
				OFS_CONFIG: config_q <= (config_q & ~wmask[12:0])
					| (avs_writedata_i[12:0] & wmask[12:0]);
				OFS_TL_DELAY: torque_limit_delay_param_q <= (torque_limit_delay_param_q
					& ~wmask[15:0]) | (avs_writedata_i[15:0] & wmask[15:0]);
				OFS_IRQ_MASK: irq_mask_q <= (irq_mask_q & ~wmask[IRQ_WIDTH-1:0])
					| (avs_writedata_i[IRQ_WIDTH-1:0] & wmask[IRQ_WIDTH-1:0]);
				default: ;
			endcase
		end
	end

	// Start edge and motion done edge
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			start_prev_q <= 1'b0;
			move_done_prev_q <= 1'b0;
		end else begin
			start_prev_q <= start_request_bit;
			move_done_prev_q <= move_done_s;
		end
	end
	assign start_rise = start_request_bit & ~start_prev_q;

	// Station index compared against count minus one without wrapping
	assign range_bad = ({1'b0, next_station_word_q} + 9'h001) > {1'b0, station_count_param};
	assign start_ok = start_rise & (state_q == ST_IDLE) & home_s;

	// Event capture
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_HOME_MISSING_BIT] = start_rise & (state_q == ST_IDLE)
			& (auto_mode | manual_mode) & ~home_s;
		irq_set[IRQ_RANGE_WARN_BIT] = start_ok & auto_mode & range_bad;
		irq_set[IRQ_DONE_BIT] = move_done_rise & ((state_q == ST_INDEX_MOVE)
			| (state_q == ST_JOG_STOP));
		irq_clr = '0;
		if (wr_go && (avs_address_i == OFS_IRQ_STATUS)) begin
			irq_clr = avs_writedata_i[IRQ_WIDTH-1:0] & wmask[IRQ_WIDTH-1:0];
		end
	end

	// Sticky status, a new event wins over the clear
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			irq_stat_q <= '0;
			irq_o <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
			irq_o <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
		end
	end

	// Movement sequencing
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
			cmd_valid_o <= 1'b0;
			cmd_kind_o <= 2'h0;
			cmd_station_o <= 8'h00;
			cmd_speed_o <= 16'h0000;
			cmd_direct_speed_o <= 1'b0;
			cmd_point_table_o <= PT_ENTRY_ONE;
			jog_release_o <= 1'b0;
			jog_to_station_o <= 1'b0;
		end else begin
			cmd_valid_o <= 1'b0;
			jog_release_o <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (start_ok && auto_mode && !range_bad) begin
						state_q <= ST_INDEX_MOVE;
						cmd_valid_o <= 1'b1;
						cmd_kind_o <= CMD_INDEX;
						cmd_station_o <= next_station_word_q;
						if (direct_speed && two_station) begin
							cmd_direct_speed_o <= 1'b1;
							cmd_speed_o <= speed_select_word_q;
							cmd_point_table_o <= PT_ENTRY_ONE;
						end else begin
							cmd_direct_speed_o <= 1'b0;
							cmd_speed_o <= 16'h0000;
							cmd_point_table_o <= speed_select_word_q[2:0];
						end
					end else if (start_ok && manual_mode) begin
						state_q <= ST_JOG_RUN;
						cmd_valid_o <= 1'b1;
						cmd_kind_o <= CMD_JOG;
						cmd_direct_speed_o <= 1'b0;
						cmd_speed_o <= 16'h0000;
						cmd_point_table_o <= PT_ENTRY_ONE;
						jog_to_station_o <= jog_style_param;
					end
				end
				ST_INDEX_MOVE: begin
					if (move_done_rise) begin
						state_q <= ST_IDLE;
					end
				end
				ST_JOG_RUN: begin
					if (!start_request_bit) begin
						state_q <= ST_JOG_STOP;
						jog_release_o <= 1'b1;
					end
				end
				ST_JOG_STOP: begin
					if (move_done_rise) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Direction of station numbering
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			cmd_direction_o <= 1'b0;
		end else begin
			cmd_direction_o <= station_direction_param;
		end
	end

	// Done and in-position flags, power-on station check
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			settle_q <= 2'h0;
			motion_done_q <= 1'b1;
			in_position_q <= 1'b0;
			tl_start_q <= 1'b0;
			tl_cancel_q <= 1'b0;
		end else begin
			tl_start_q <= 1'b0;
			tl_cancel_q <= 1'b0;
			if (settle_q != SYNC_SETTLE_CYC[1:0]) begin
				settle_q <= settle_q + 2'h1;
				if (settle_q == SYNC_SETTLE_CYC[1:0] - 2'h1) begin
					in_position_q <= at_station_s;
					tl_start_q <= at_station_s;
				end
			end
			if (cmd_valid_o) begin
				motion_done_q <= 1'b0;
				in_position_q <= 1'b0;
				tl_cancel_q <= 1'b1;
			end else if (move_done_rise && (state_q == ST_INDEX_MOVE)) begin
				motion_done_q <= 1'b1;
				in_position_q <= 1'b1;
				tl_start_q <= 1'b1;
			end else if (move_done_rise && (state_q == ST_JOG_STOP)) begin
				motion_done_q <= 1'b1;
				in_position_q <= jog_to_station_o | at_station_s;
				tl_start_q <= 1'b1;
			end
		end
	end

	// Torque limit delay
	assign tl_bus.start = tl_start_q;
	assign tl_bus.cancel = tl_cancel_q;
	assign tl_bus.delay = torque_limit_delay_param_q;

	isj_tl_delay #(
		.UNIT_CYC(UNIT_CYC)
	) u_tl_delay (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.tl(tl_bus.tmr)
	);

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			tl_second_o <= 1'b0;
			motion_done_flag_o <= 1'b0;
			in_position_flag_o <= 1'b0;
		end else begin
			tl_second_o <= tl_bus.expired & ~tl_cancel_q;
			motion_done_flag_o <= motion_done_q;
			in_position_flag_o <= in_position_q;
		end
	end
endmodule

// ==== tb/isj_motor_model.sv ====
// Behavioural motion engine answering the sequencer's commands
module isj_motor_model
	import isj_pkg::*;
#(
	parameter int DLY = 20
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic cmd_valid_i,
	input wire logic [1:0] kind_i,
	input wire logic release_i,
	output logic move_done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic run_q;
	int cnt_q;
	// Index runs at once, jog waits for release, then stops after DLY
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			move_done_o <= 1'b1;
			run_q <= 1'b0;
			cnt_q <= 0;
		end else if (cmd_valid_i) begin
			move_done_o <= 1'b0;
			run_q <= (kind_i == CMD_INDEX);
			cnt_q <= DLY;
		end else if (release_i) begin
			run_q <= 1'b1;
		end else if (run_q && cnt_q > 0) begin
			cnt_q <= cnt_q - 1;
		end else if (run_q) begin
			move_done_o <= 1'b1;
			run_q <= 1'b0;
		end
	end
endmodule

// ==== tb/isj_sequencer_sva.sv ====
// Concurrent checks on the sequencer's ports
module isj_sequencer_sva
	import isj_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire logic home_done_i,
	input wire logic at_station_i,
	input wire logic cmd_valid_o,
	input wire logic [1:0] cmd_kind_o,
	input wire logic cmd_direct_speed_o,
	input wire logic [2:0] cmd_point_table_o,
	input wire logic jog_release_o,
	input wire logic tl_second_o,
	input wire logic motion_done_flag_o,
	input wire logic in_position_flag_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_busy;
		!motion_done_flag_o && !in_position_flag_o;
	endsequence
	sequence s_pulse;
		cmd_valid_o ##1 !cmd_valid_o;
	endsequence
	chk_valid_pulse: assert property (cmd_valid_o |-> s_pulse)
		else $error("command strobe longer than one cycle");
	chk_flags_drop: assert property (cmd_valid_o |-> ##2 s_busy)
		else $error("done or in-position kept at move start");
	chk_busy_ignore: assert property (cmd_valid_o |-> motion_done_flag_o)
		else $error("command issued while busy");
	chk_home_needed: assert property (cmd_valid_o |-> $past(home_done_i, 4))
		else $error("command issued without home return");
	chk_jog_entry: assert property (cmd_valid_o && cmd_kind_o == CMD_JOG
		|-> cmd_point_table_o == PT_ENTRY_ONE)
		else $error("jog not using entry one");
	chk_direct_ramp: assert property (cmd_valid_o && cmd_direct_speed_o
		|-> cmd_point_table_o == PT_ENTRY_ONE)
		else $error("direct speed ramps not from entry one");
	chk_release_jog: assert property (jog_release_o |-> cmd_kind_o == CMD_JOG)
		else $error("release outside jog");
	chk_tl_inpos: assert property ($rose(tl_second_o) |-> motion_done_flag_o
		&& (in_position_flag_o || cmd_kind_o == CMD_JOG))
		else $error("second torque limit before stop or in-position");
	chk_power_inpos: assert property ($rose(rst_n_i) && at_station_i
		|-> ##[1:6] in_position_flag_o)
		else $error("in-position missing at power-on");
	chk_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o)
		else $error("bus access not answered");
	chk_bus_release: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
endmodule

bind isj_sequencer isj_sequencer_sva u_isj_sequencer_sva (.sys_clk_i, .rst_n_i, .avs_read_i,
	.avs_write_i, .avs_waitrequest_o, .home_done_i, .at_station_i, .cmd_valid_o, .cmd_kind_o,
	.cmd_direct_speed_o, .cmd_point_table_o, .jog_release_o, .tl_second_o,
	.motion_done_flag_o, .in_position_flag_o);

// ==== tb/isj_sequencer_test.sv ====
// Self-checking testbench of the station indexer jog sequencer
module isj_sequencer_test
	import isj_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, home = 1'b0, at_st = 1'b1;
	logic [5:0] addr = 6'h00;
	logic [31:0] wd = 32'h0000_0000, rdq, rdata, d;
	logic wq, wait_o, mdone, cv, rel, jts, tl, done, inpos, irq, dirs, dsp;
	logic [1:0] kind;
	logic [7:0] sta;
	logic [15:0] spd;
	logic [2:0] pt;
	int miscompares = 0, num_checks = 0, ncmd = 0, nrel = 0;
	always #2.5 clk = ~clk;
	isj_sequencer #(.UNIT_CYC(10)) u_isj_sequencer (.sys_clk_i(clk), .rst_n_i(rst_n),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
		.home_done_i(home), .at_station_i(at_st), .move_done_i(mdone), .cmd_valid_o(cv),
		.cmd_kind_o(kind), .cmd_station_o(sta), .cmd_speed_o(spd), .cmd_direct_speed_o(dsp),
		.cmd_point_table_o(pt), .cmd_direction_o(dirs), .jog_release_o(rel),
		.jog_to_station_o(jts), .tl_second_o(tl), .motion_done_flag_o(done),
		.in_position_flag_o(inpos), .irq_o(irq));
	isj_motor_model u_isj_motor_model (.clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cv),
		.kind_i(kind), .release_i(rel), .move_done_o(mdone));
	// Settled copies taken mid-cycle
	always @(negedge clk) begin
		wq <= wait_o;
		rdq <= rdata;
		if (cv === 1'b1) ncmd++;
		if (rel === 1'b1) nrel++;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic bw(input logic [5:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wd <= v;
		wr <= 1'b1;
		do @(posedge clk); while (wq !== 1'b0);
		wr <= 1'b0;
	endtask
	task automatic br(input logic [5:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		do @(posedge clk); while (wq !== 1'b0);
		v = rdq;
		rd <= 1'b0;
	endtask
	task automatic rchk(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] v;
		br(a, v);
		chk(v, e);
	endtask
	// Mode written first, then start raised; count commands issued
	task automatic go(input logic [31:0] m, input int n);
		int n0;
		n0 = ncmd;
		bw(OFS_CTRL, m);
		bw(OFS_CTRL, m | 32'h0000_0001);
		repeat (6) @(negedge clk);
		chk(ncmd - n0, n);
	endtask
	task automatic wait_done;
		for (int i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk);
		chk(done, 1'b1);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		complete_run;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rchk(OFS_CONFIG, 32'h0000_1008);
		rchk(OFS_IRQ_MASK, 32'h0000_0000);
		rchk(OFS_CTRL, 32'h0000_0000);
		rchk(6'h3C, 32'h0000_0000);
		@(negedge clk);
		chk(dirs, 1'b0);
		chk(inpos, 1'b1);
		bw(OFS_IRQ_MASK, 32'h0000_0007);
		go(32'h0000_0006, 0);
		rchk(OFS_IRQ_STATUS, 32'h0000_0001);
		chk(irq, 1'b1);
		bw(OFS_IRQ_STATUS, 32'h0000_0001);
		repeat (3) @(negedge clk);
		chk(irq, 1'b0);
		@(posedge clk);
		home <= 1'b1;
		bw(OFS_NEXT_STATION, 32'h0000_0008);
		go(32'h0000_0006, 0);
		rchk(OFS_IRQ_STATUS, 32'h0000_0002);
		bw(OFS_IRQ_STATUS, 32'h0000_0002);
		bw(OFS_NEXT_STATION, 32'h0000_0007);
		bw(OFS_SPEED_SELECT, 32'h0000_0002);
		bw(OFS_TL_DELAY, 32'h0000_0003);
		go(32'h0000_0006, 1);
		chk({kind, sta, pt}, {CMD_INDEX, 8'h07, 3'h2});
		chk({done, inpos}, 2'b00);
		bw(OFS_NEXT_STATION, 32'h0000_0001);
		go(32'h0000_0006, 0);
		chk(sta, 8'h07);
		wait_done;
		chk(inpos, 1'b1);
		repeat (20) @(negedge clk);
		chk(tl, 1'b0);
		repeat (20) @(negedge clk);
		chk(tl, 1'b1);
		rchk(OFS_IRQ_STATUS, 32'h0000_0004);
		bw(OFS_CONFIG, 32'h0000_1E08);
		bw(OFS_SPEED_SELECT, 32'h0000_1234);
		go(32'h0000_0006, 1);
		chk({dsp, spd, pt, dirs}, {1'b1, 16'h1234, 3'h1, 1'b1});
		wait_done;
		go(32'h0000_0004, 0);
		go(32'h0000_0000, 0);
		bw(OFS_CONFIG, 32'h0000_1108);
		bw(OFS_NEXT_STATION, 32'h0000_0009);
		bw(OFS_IRQ_STATUS, 32'h0000_0007);
		go(32'h0000_0002, 1);
		chk({kind, pt, jts}, {CMD_JOG, 3'h1, 1'b1});
		br(OFS_IRQ_STATUS, d);
		chk(d[1], 1'b0);
		repeat (50) @(negedge clk);
		chk(done, 1'b0);
		bw(OFS_CTRL, 32'h0000_0002);
		wait_done;
		chk(inpos, 1'b1);
		bw(OFS_CONFIG, 32'h0000_1008);
		at_st <= 1'b0;
		go(32'h0000_0002, 1);
		chk(jts, 1'b0);
		bw(OFS_CTRL, 32'h0000_0002);
		wait_done;
		chk(inpos, 1'b0);
		repeat (45) @(negedge clk);
		chk(tl, 1'b1);
		chk(nrel, 2);
		complete_run;
	end
endmodule
